// file: pkg/tmr_pkg.sv
`default_nettype none
package tmr_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_MASK    = 8'h6F;
    localparam logic [7:0] OFS_FLAGS   = 8'h36;
    localparam logic [7:0] OFS_CTRL_A  = 8'h80;
    localparam logic [7:0] OFS_CTRL_B  = 8'h81;
    localparam logic [7:0] OFS_CTRL_C  = 8'h82;
    localparam logic [7:0] OFS_CNT_L   = 8'h84;
    localparam logic [7:0] OFS_CNT_H   = 8'h85;
    localparam logic [7:0] OFS_CAP_L   = 8'h86;
    localparam logic [7:0] OFS_CAP_H   = 8'h87;
    localparam logic [7:0] OFS_CMPA_L  = 8'h88;
    localparam logic [7:0] OFS_CMPA_H  = 8'h89;
    localparam logic [7:0] OFS_CMPB_L  = 8'h8A;
    localparam logic [7:0] OFS_CMPB_H  = 8'h8B;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_EDGE_SEL = 6;
    localparam int BIT_FORCE_A  = 7;
    localparam int BIT_FORCE_B  = 6;
    localparam int BIT_CAP      = 5;
    localparam int BIT_CMPB     = 2;
    localparam int BIT_CMPA     = 1;
    localparam int BIT_OVF      = 0;

    localparam logic [7:0] MASK_IRQ_BITS = 8'h27;
    localparam logic [7:0] CTRL_B_BITS   = 8'hDF;
    localparam logic [7:0] RESET_BYTE    = 8'h00;
    localparam logic [15:0] RESET_WORD   = 16'h0000;
    localparam logic [15:0] MAX_VALUE    = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT     = 16'h00FF;
    localparam logic [15:0] TOP_9BIT     = 16'h01FF;
    localparam logic [15:0] TOP_10BIT    = 16'h03FF;

    // prescale divide counts
    localparam int DIV_8    = 8;
    localparam int DIV_64   = 64;
    localparam int DIV_256  = 256;
    localparam int DIV_1024 = 1024;

    // ------------------------------------------------------------
    // clock select codes
    // ------------------------------------------------------------
    localparam logic [2:0] CS_STOP   = 3'h0;
    localparam logic [2:0] CS_DIV1   = 3'h1;
    localparam logic [2:0] CS_DIV8   = 3'h2;
    localparam logic [2:0] CS_DIV64  = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1K  = 3'h5;
    localparam logic [2:0] CS_EXTF   = 3'h6;
    localparam logic [2:0] CS_EXTR   = 3'h7;

    // waveform modes of interest
    localparam logic [3:0] WM_NORMAL   = 4'h0;
    localparam logic [3:0] WM_CTC_A    = 4'h4;
    localparam logic [3:0] WM_CTC_CAP  = 4'hC;
    localparam logic [3:0] WM_PFC_CAP  = 4'h8;
    localparam logic [3:0] WM_PC_CAP   = 4'hA;
    localparam logic [3:0] WM_FAST_CAP = 4'hE;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tmr_bus_t;

    typedef struct packed {
        logic cap;
        logic cmpb;
        logic cmpa;
        logic ovf;
    } tmr_irq_t;

    typedef enum logic [1:0] {
        DIR_UP,
        DIR_DOWN
    } tmr_dir_t;

endpackage : tmr_pkg
`default_nettype wire

// file: hdl/tmr_timer16.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// R01 - capture fires on falling pin edge when edge select is 0, rising when 1
// R02 - capture copies counter into capture register and sets capture flag
// R03 - capture pin ignored while capture register is the TOP value
// R04 - software writes zero to reserved control B bit 5
// R05 - clock select 000 stops; 001..101 divide io clock by 1,8,64,256,1024
// R06 - code 110 counts falling external pin edges, 111 rising edges
// R07 - external pin clocks the counter even when configured as an output
// R08 - force bits cause compare output action, only in non-PWM modes
// R09 - software writes force bits as zero while in PWM modes
// R10 - forced compare sets no flag and never clears the counter
// R11 - force bits are strobes and always read back zero
// R12 - 16-bit counter accessed atomically through one shared high-byte latch
// R13 - counter write suppresses compare matches on the next timer clock
// R14 - two compare registers compared continuously, driving flags and outputs; outputs here driven in non-PWM modes only
// R15 - compare writes update both bytes at once via the high-byte latch
// R16 - capture source is the pin or, optionally, the comparator output
// R17 - capture reads return both bytes from one instant via the latch
// R18 - mask bits 5,2,1,0 enable capture, cmp B, cmp A, overflow irqs
// R19 - in capture-as-TOP modes the capture flag sets when counter hits TOP
// R20 - compare flag sets in timer clock after counter equals compare value
// R21 - overflow flag sets at overflow in normal/CLEAR_ON_MATCH_MODE, else per waveform mode
// R22 - flags clear on vector execution or on writing one to the bit
// R23 - writing zero leaves flags alone; unused bits read zero
module tmr_timer16
    import tmr_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // register port
    input  wire tmr_bus_t   bus,
    output logic      [7:0] rdata,
    // pins
    input  wire logic       capture_input_pin,
    input  wire logic       comparator_out,
    input  wire logic       external_count_pin,
    output logic            waveform_out_a,
    output logic            waveform_out_b,
    // interrupt handling
    input  wire logic       global_irq_enable,
    input  wire tmr_irq_t   vector_ack,
    output tmr_irq_t        irq_req
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]  ctrl_a_ff;
    logic [7:0]  ctrl_b_ff;
    logic [7:0]  mask_ff;
    logic [7:0]  high_latch_ff;
    logic [15:0] count_ff;
    logic [15:0] cmpa_ff;
    logic [15:0] cmpb_ff;
    logic [15:0] cap_ff;
    tmr_irq_t    flag_ff;
    logic        cmpa_hit_ff;
    logic        cmpb_hit_ff;
    logic        block_ff;
    logic        cap_pin_ff;
    logic        ext_pin_ff;
    logic        cap_src_sel_ff;
    logic [9:0]  prescale_ff;
    tmr_dir_t    dir_ff;
    logic        wave_a_ff;
    logic        wave_b_ff;

    logic [3:0]  wave_mode;
    logic [2:0]  clk_sel;
    logic        tick;
    logic        cap_is_top;
    logic        pwm_mode;
    logic [15:0] top_value;
    logic        at_top;
    logic        cap_level;
    logic        cap_event;
    logic        ovf_event;
    logic        cmpa_now;
    logic        cmpb_now;
    logic        cnt_wr;
    logic        force_a;
    logic        force_b;
    logic [15:0] nxt_count;

    assign wave_mode = {ctrl_b_ff[4:3], ctrl_a_ff[1:0]};
    assign clk_sel   = ctrl_b_ff[2:0];
    assign cnt_wr    = bus.wr && (bus.addr == OFS_CNT_L);

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_a_ff      <= RESET_BYTE;
            ctrl_b_ff      <= RESET_BYTE;
            mask_ff        <= RESET_BYTE;
            high_latch_ff  <= RESET_BYTE;
            cmpa_ff        <= RESET_WORD;
            cmpb_ff        <= RESET_WORD;
            cap_src_sel_ff <= 1'b0;
        end
        else if (bus.wr)
        begin
            case (bus.addr)
                OFS_CTRL_A: ctrl_a_ff <= bus.wdata;
                // reserved bit kept zero whatever software writes
                OFS_CTRL_B: ctrl_b_ff <= bus.wdata & CTRL_B_BITS; // R04
                OFS_MASK:   mask_ff   <= bus.wdata & MASK_IRQ_BITS; // R18 R23
                OFS_CTRL_C: cap_src_sel_ff <= bus.wdata[0]; // R16
                OFS_CNT_H,
                OFS_CAP_H,
                OFS_CMPA_H,
                OFS_CMPB_H: high_latch_ff <= bus.wdata; // R12
                OFS_CMPA_L: cmpa_ff <= {high_latch_ff, bus.wdata}; // R15
                OFS_CMPB_L: cmpb_ff <= {high_latch_ff, bus.wdata}; // R15
                default:    ;
            endcase
        end
        else if (bus.rd && (bus.addr == OFS_CNT_L))
        begin
            high_latch_ff <= count_ff[15:8]; // R12
        end
        else if (bus.rd && (bus.addr == OFS_CAP_L))
        begin
            high_latch_ff <= cap_ff[15:8]; // R17
        end
    end

    // ------------------------------------------------------------
    // prescaler and clock select
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            prescale_ff <= '0;
        else
            prescale_ff <= prescale_ff + 10'h001;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ext_pin_ff <= 1'b0;
            cap_pin_ff <= 1'b0;
        end
        else
        begin
            // pin sampled directly, port direction is irrelevant
            ext_pin_ff <= external_count_pin; // R07
            cap_pin_ff <= cap_level;
        end
    end

    always_comb
    begin
        case (clk_sel) // R05 R06
            CS_STOP:   tick = 1'b0;
            CS_DIV1:   tick = 1'b1;
            CS_DIV8:   tick = (prescale_ff[2:0] == 3'((DIV_8 - 1)));
            CS_DIV64:  tick = (prescale_ff[5:0] == 6'((DIV_64 - 1)));
            CS_DIV256: tick = (prescale_ff[7:0] == 8'((DIV_256 - 1)));
            CS_DIV1K:  tick = (prescale_ff == 10'((DIV_1024 - 1)));
            CS_EXTF:   tick = ext_pin_ff && !external_count_pin;
            CS_EXTR:   tick = !ext_pin_ff && external_count_pin;
            default:   tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // mode decode and counter
    // ------------------------------------------------------------
    always_comb
    begin
        cap_is_top = (wave_mode == WM_CTC_CAP) || (wave_mode == WM_PFC_CAP)
                  || (wave_mode == WM_PC_CAP)  || (wave_mode == WM_FAST_CAP);
        pwm_mode   = !((wave_mode == WM_NORMAL) || (wave_mode == WM_CTC_A)
                  || (wave_mode == WM_CTC_CAP));
        case (wave_mode)
            4'h1, 4'h5: top_value = TOP_8BIT;
            4'h2, 4'h6: top_value = TOP_9BIT;
            4'h3, 4'h7: top_value = TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF: top_value = cmpa_ff;
            4'h8, 4'hA, 4'hC, 4'hE: top_value = cap_ff;
            default:    top_value = MAX_VALUE;
        endcase
    end

    assign at_top = (count_ff == top_value);

    // dual-slope modes are 1,2,3,8,9,10,11
    logic dual_slope;
    assign dual_slope = (wave_mode[3:2] == 2'h0 && wave_mode != WM_NORMAL)
                     || (wave_mode[3:2] == 2'h2);

    always_comb
    begin
        nxt_count = count_ff;
        if (dual_slope)
        begin
            if (dir_ff == DIR_DOWN)
                nxt_count = count_ff - 16'h0001;
            else if (!at_top)
                nxt_count = count_ff + 16'h0001;
            else
                nxt_count = count_ff - 16'h0001;
        end
        else if (at_top && wave_mode != WM_NORMAL)
            nxt_count = RESET_WORD;
        else
            nxt_count = count_ff + 16'h0001;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_ff <= RESET_WORD;
            dir_ff   <= DIR_UP;
        end
        else if (cnt_wr)
            count_ff <= {high_latch_ff, bus.wdata}; // R12
        else if (tick)
        begin
            count_ff <= nxt_count;
            if (dual_slope && at_top)
                dir_ff <= DIR_DOWN;
            else if (count_ff == RESET_WORD)
                dir_ff <= DIR_UP;
        end
    end

    // ------------------------------------------------------------
    // compare and capture
    // ------------------------------------------------------------
    assign cmpa_now = (count_ff == cmpa_ff); // R14
    assign cmpb_now = (count_ff == cmpb_ff); // R14

    // block lasts until the next timer tick, even while stopped
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            block_ff    <= 1'b0;
            cmpa_hit_ff <= 1'b0;
            cmpb_hit_ff <= 1'b0;
        end
        else
        begin
            if (cnt_wr)
                block_ff <= 1'b1; // R13
            else if (tick)
                block_ff <= 1'b0;
            cmpa_hit_ff <= tick && cmpa_now && !block_ff; // R13 R20
            cmpb_hit_ff <= tick && cmpb_now && !block_ff; // R13 R20
        end
    end

    assign cap_level = cap_src_sel_ff ? comparator_out : capture_input_pin; // R16
    assign cap_event = !cap_is_top // R03
                    && (ctrl_b_ff[BIT_EDGE_SEL] ? (!cap_pin_ff && cap_level)
                                                : (cap_pin_ff && !cap_level)); // R01

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            cap_ff <= RESET_WORD;
        else if (bus.wr && bus.addr == OFS_CAP_L && cap_is_top)
            cap_ff <= {high_latch_ff, bus.wdata};
        else if (cap_event)
            cap_ff <= count_ff; // R02
    end

    // ------------------------------------------------------------
    // flags
    // ------------------------------------------------------------
    always_comb
    begin
        if (wave_mode == WM_NORMAL || wave_mode == WM_CTC_A || wave_mode == WM_CTC_CAP)
            ovf_event = tick && (count_ff == MAX_VALUE); // R21
        else if (dual_slope)
            ovf_event = tick && (count_ff == RESET_WORD) && dir_ff == DIR_DOWN; // R21
        else
            ovf_event = tick && at_top; // R21
    end

    logic wr_flags;
    assign wr_flags = bus.wr && (bus.addr == OFS_FLAGS);

    // set wins over a same-cycle clear; zero writes leave flags alone
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            flag_ff <= '0;
        else
        begin
            flag_ff.cap  <= (cap_event || (cap_is_top && tick && at_top)) // R02 R19
                         || (flag_ff.cap && !vector_ack.cap
                             && !(wr_flags && bus.wdata[BIT_CAP])); // R22 R23
            flag_ff.cmpb <= cmpb_hit_ff // R20
                         || (flag_ff.cmpb && !vector_ack.cmpb
                             && !(wr_flags && bus.wdata[BIT_CMPB])); // R22
            flag_ff.cmpa <= cmpa_hit_ff // R20
                         || (flag_ff.cmpa && !vector_ack.cmpa
                             && !(wr_flags && bus.wdata[BIT_CMPA])); // R22
            flag_ff.ovf  <= ovf_event // R21
                         || (flag_ff.ovf && !vector_ack.ovf
                             && !(wr_flags && bus.wdata[BIT_OVF])); // R22
        end
    end

    always_comb
    begin
        irq_req.cap  = global_irq_enable && mask_ff[BIT_CAP]  && flag_ff.cap; // R18
        irq_req.cmpb = global_irq_enable && mask_ff[BIT_CMPB] && flag_ff.cmpb; // R18
        irq_req.cmpa = global_irq_enable && mask_ff[BIT_CMPA] && flag_ff.cmpa; // R18
        irq_req.ovf  = global_irq_enable && mask_ff[BIT_OVF]  && flag_ff.ovf; // R18
    end

    // ------------------------------------------------------------
    // waveform outputs (non-PWM actions; PWM tables out of scope)
    // ------------------------------------------------------------
    assign force_a = bus.wr && bus.addr == OFS_CTRL_C && bus.wdata[BIT_FORCE_A]
                  && !pwm_mode; // R08
    assign force_b = bus.wr && bus.addr == OFS_CTRL_C && bus.wdata[BIT_FORCE_B]
                  && !pwm_mode; // R08

    function automatic logic wave_next(input logic [1:0] com, input logic cur);
        case (com)
            2'b01:   wave_next = !cur;
            2'b10:   wave_next = 1'b0;
            2'b11:   wave_next = 1'b1;
            default: wave_next = cur;
        endcase
    endfunction : wave_next

    // forced strobes drive only the output path, never flags or counter
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wave_a_ff <= 1'b0;
            wave_b_ff <= 1'b0;
        end
        else
        begin
            if (force_a || (cmpa_hit_ff && !pwm_mode))
                wave_a_ff <= wave_next(ctrl_a_ff[7:6], wave_a_ff); // R08 R10 R14
            if (force_b || (cmpb_hit_ff && !pwm_mode))
                wave_b_ff <= wave_next(ctrl_a_ff[5:4], wave_b_ff); // R08 R10 R14
        end
    end

    assign waveform_out_a = wave_a_ff;
    assign waveform_out_b = wave_b_ff;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb
    begin
        case (bus.addr)
            OFS_CTRL_A: rdata = ctrl_a_ff;
            OFS_CTRL_B: rdata = ctrl_b_ff;
            OFS_CTRL_C: rdata = {7'h00, cap_src_sel_ff}; // R11
            OFS_MASK:   rdata = mask_ff;
            OFS_FLAGS:  rdata = {2'h0, flag_ff.cap, 2'h0, flag_ff.cmpb,
                                 flag_ff.cmpa, flag_ff.ovf}; // R23
            OFS_CNT_L:  rdata = count_ff[7:0];
            OFS_CAP_L:  rdata = cap_ff[7:0]; // R17
            OFS_CMPA_L: rdata = cmpa_ff[7:0];
            OFS_CMPB_L: rdata = cmpb_ff[7:0];
            OFS_CNT_H,
            OFS_CAP_H:  rdata = high_latch_ff; // R12
            OFS_CMPA_H: rdata = cmpa_ff[15:8];
            OFS_CMPB_H: rdata = cmpb_ff[15:8];
            default:    rdata = RESET_BYTE;
        endcase
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_cap_copy: assert property (@(posedge clock) disable iff (!reset_n) // R02
        cap_event |=> (cap_ff == $past(count_ff)) && flag_ff.cap)
        else $error("capture did not copy counter");
    a_cap_top_off: assert property (@(posedge clock) disable iff (!reset_n) // R03
        cap_is_top && !bus.wr |=> $stable(cap_ff))
        else $error("capture active while capture is TOP");
    a_cmp_block: assert property (@(posedge clock) disable iff (!reset_n) // R13
        (block_ff && tick) |=> !cmpa_hit_ff && !cmpb_hit_ff)
        else $error("compare not blocked after counter write");
    a_cmpa_flag: assert property (@(posedge clock) disable iff (!reset_n) // R20
        (tick && cmpa_now && !block_ff) |-> ##2 flag_ff.cmpa)
        else $error("compare A flag not set");
    a_force_noflag: assert property (@(posedge clock) disable iff (!reset_n) // R10
        (force_a && !cmpa_hit_ff && !flag_ff.cmpa) |=> !flag_ff.cmpa)
        else $error("forced compare set a flag");
    a_force_read: assert property (@(posedge clock) disable iff (!reset_n) // R11
        (bus.addr == OFS_CTRL_C) |-> rdata[7:6] == 2'h0)
        else $error("force bits read non-zero");
    a_irq_gate: assert property (@(posedge clock) disable iff (!reset_n) // R18
        irq_req.ovf |-> global_irq_enable && mask_ff[BIT_OVF] && flag_ff.ovf)
        else $error("overflow request without enable");
    a_flag_clear: assert property (@(posedge clock) disable iff (!reset_n) // R22
        (wr_flags && bus.wdata[BIT_OVF] && !ovf_event) |=> !flag_ff.ovf)
        else $error("overflow flag not cleared by one");
    a_flag_keep: assert property (@(posedge clock) disable iff (!reset_n) // R23
        (wr_flags && !bus.wdata[BIT_CMPB] && flag_ff.cmpb && !vector_ack.cmpb)
        |=> flag_ff.cmpb)
        else $error("zero write cleared flag");
    a_stop_hold: assert property (@(posedge clock) disable iff (!reset_n) // R05
        (clk_sel == CS_STOP && !cnt_wr) |=> $stable(count_ff))
        else $error("counter moved while stopped");

endmodule : tmr_timer16
`default_nettype wire

// file: testbench/timer16_capture_compare_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module timer16_capture_compare_control_tb_top
    import tmr_pkg::*;
;
    // ------------------------------------------------------------
    // design connections
    // ------------------------------------------------------------
    logic        clock, reset_n, capture_input_pin, comparator_out, external_count_pin;
    logic        waveform_out_a, waveform_out_b, global_irq_enable;
    tmr_bus_t    bus;
    tmr_irq_t    vector_ack, irq_req;
    logic [7:0]  rdata, b;
    logic [15:0] val, got;
    int          fail_count, checks, cycles;

    tmr_timer16 tmr_timer16_inst (.clock(clock), .reset_n(reset_n), .bus(bus), .rdata(rdata),
        .capture_input_pin(capture_input_pin), .comparator_out(comparator_out),
        .external_count_pin(external_count_pin), .waveform_out_a(waveform_out_a),
        .waveform_out_b(waveform_out_b), .global_irq_enable(global_irq_enable),
        .vector_ack(vector_ack), .irq_req(irq_req));

    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask : wr8
    task automatic rd8(input logic [7:0] a, input logic r, output logic [7:0] d);
        @(posedge clock);
        bus <= '{wr: 1'b0, rd: r, addr: a, wdata: 8'h00};
        @(posedge clock);
        d = rdata;
        bus.rd <= 1'b0;
    endtask : rd8
    task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
        wr8(lo + 8'h01, v[15:8]);
        wr8(lo, v[7:0]);
    endtask : wr16
    task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
        rd8(lo, 1'b1, v[7:0]);
        rd8(lo + 8'h01, 1'b0, v[15:8]);
    endtask : rd16
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk8
    task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk16
    function automatic int div_of(input logic [2:0] c);
        case (c)
            CS_DIV8:   return DIV_8;
            CS_DIV64:  return DIV_64;
            CS_DIV256: return DIV_256;
            CS_DIV1K:  return DIV_1024;
            default:   return 1;
        endcase
    endfunction : div_of
    task automatic run(input logic [2:0] c, input int n);
        wr8(OFS_CTRL_B, {5'h00, c});
        repeat (n) @(posedge clock);
        wr8(OFS_CTRL_B, RESET_BYTE);
    endtask : run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------
    // clock, reset, timeout
    // ------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // ceiling well above the longest prescaler run
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            fail_count++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        {reset_n, capture_input_pin, comparator_out, external_count_pin} = 4'h0;
        bus = '0;
        global_irq_enable = 1'b0;
        vector_ack = '0;
        {fail_count, checks, cycles} = 0;
        void'($urandom(10));
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        rd8(OFS_MASK, 1'b0, b);
        chk8("mask reset", RESET_BYTE, b);
        wr8(OFS_MASK, 8'hFF);
        rd8(OFS_MASK, 1'b0, b);
        chk8("mask bits", 8'h27, b);
        wr8(OFS_CTRL_B, 8'hDF);
        rd8(OFS_CTRL_B, 1'b0, b);
        chk8("control b", 8'hDF, b);
        wr8(OFS_CTRL_B, RESET_BYTE);
        wr8(OFS_CTRL_C, 8'hC0);
        rd8(OFS_CTRL_C, 1'b0, b);
        chk8("force bits", RESET_BYTE, b);
        val = 16'h0100 + 16'($urandom_range(32'hE000));
        wr16(OFS_CMPA_L, val);
        rd16(OFS_CMPA_L, got);
        chk16("compare a", val, got);
        // counter write equal to compare value must not raise a match
        wr16(OFS_CNT_L, val);
        wr8(OFS_FLAGS, 8'hFF);
        run(CS_DIV1, 3);
        rd8(OFS_FLAGS, 1'b0, b);
        chk8("blocked match", 8'h00, b & 8'h02);
        wr16(OFS_CNT_L, val - 16'h0003);
        run(CS_DIV1, 10);
        rd8(OFS_FLAGS, 1'b0, b);
        chk8("match flag", 8'h02, b & 8'h02);
        global_irq_enable <= 1'b1;
        @(negedge clock);
        chk8("irq a on", 8'h01, {7'h00, irq_req.cmpa});
        global_irq_enable <= 1'b0;
        @(negedge clock);
        chk8("irq a off", 8'h00, {7'h00, irq_req.cmpa});
        wr8(OFS_FLAGS, 8'h00);
        rd8(OFS_FLAGS, 1'b0, b);
        chk8("flag kept", 8'h02, b & 8'h02);
        wr8(OFS_FLAGS, 8'h02);
        rd8(OFS_FLAGS, 1'b0, b);
        chk8("flag cleared", 8'h00, b & 8'h02);
        wr16(OFS_CNT_L, MAX_VALUE - 16'h0003);
        run(CS_DIV1, 10);
        rd8(OFS_FLAGS, 1'b0, b);
        chk8("overflow flag", 8'h01, b & 8'h01);
        @(posedge clock);
        vector_ack <= '{cap: 1'b0, cmpb: 1'b0, cmpa: 1'b0, ovf: 1'b1};
        @(posedge clock);
        vector_ack <= '0;
        rd8(OFS_FLAGS, 1'b0, b);
        chk8("vector clear", 8'h00, b & 8'h01);
        wr8(OFS_CTRL_A, 8'h50);
        wr8(OFS_FLAGS, 8'hFF);
        b = {6'h00, waveform_out_b, waveform_out_a};
        wr8(OFS_CTRL_C, 8'hC0);
        repeat (2) @(posedge clock);
        chk8("forced output", ~b & 8'h03, {6'h00, waveform_out_b, waveform_out_a});
        rd8(OFS_FLAGS, 1'b0, b);
        chk8("forced no flag", 8'h00, b & 8'h06);
        wr8(OFS_CTRL_A, RESET_BYTE);
        for (int c = 1; c <= 5; c++)
        begin
            wr16(OFS_CNT_L, RESET_WORD);
            run(3'(c), 16 * div_of(3'(c)));
            rd16(OFS_CNT_L, got);
            chk8("prescale", 8'h01, {7'h00, got >= 16'h000F && got <= 16'h0014});
        end
        repeat (20) @(posedge clock);
        rd16(OFS_CNT_L, val);
        chk16("stopped", got, val);
        for (int c = 6; c <= 7; c++)
        begin
            wr16(OFS_CNT_L, RESET_WORD);
            wr8(OFS_CTRL_B, {5'h00, 3'(c)});
            for (int t = 0; t < 5; t++)
            begin
                @(posedge clock);
                external_count_pin <= ~external_count_pin;
                repeat (3) @(posedge clock);
            end
            wr8(OFS_CTRL_B, RESET_BYTE);
            external_count_pin <= 1'b0;
            rd16(OFS_CNT_L, got);
            chk16("pin count", (c == 7) ? 16'h0003 : 16'h0002, got);
        end
        // every edge polarity on both capture sources
        for (int s = 0; s < 4; s++)
        begin
            @(posedge clock);
            if (s[1]) comparator_out <= ~s[0];
            else capture_input_pin <= ~s[0];
            wr8(OFS_CTRL_C, {7'h00, s[1]});
            wr8(OFS_CTRL_B, {1'b0, s[0], 6'h00});
            val = 16'($urandom);
            wr16(OFS_CNT_L, val);
            wr8(OFS_FLAGS, 8'hFF);
            if (s[1]) comparator_out <= s[0];
            else capture_input_pin <= s[0];
            repeat (4) @(posedge clock);
            rd16(OFS_CAP_L, got);
            chk16("capture value", val, got);
            rd8(OFS_FLAGS, 1'b0, b);
            chk8("capture flag", 8'h20, b & 8'h20);
            wr8(OFS_FLAGS, 8'hFF);
            if (s[1]) comparator_out <= ~s[0];
            else capture_input_pin <= ~s[0];
            repeat (4) @(posedge clock);
            rd8(OFS_FLAGS, 1'b0, b);
            chk8("wrong edge", 8'h00, b & 8'h20);
        end
        // capture register as top: pin edges are ignored
        wr8(OFS_CTRL_C, RESET_BYTE);
        wr8(OFS_CTRL_B, 8'h58);
        wr16(OFS_CAP_L, 16'h1234);
        wr16(OFS_CNT_L, 16'h0001);
        wr8(OFS_FLAGS, 8'hFF);
        capture_input_pin <= 1'b1;
        repeat (4) @(posedge clock);
        rd16(OFS_CAP_L, got);
        chk16("top capture", 16'h1234, got);
        report_and_stop();
    end
endmodule : timer16_capture_compare_control_tb_top
`default_nettype wire
